/* hdl/sibc_params.svh */
// Register indices, field positions, reset values and timing of the bus control block.
`ifndef SIBC_PARAMS_SVH
`define SIBC_PARAMS_SVH
`define SIBC_IDX_CTL1 10'h166
`define SIBC_IDX_CTL2 10'h167
`define SIBC_IDX_MODE2 10'h169
`define SIBC_IDX_STAT 10'h16f
`define SIBC_ADDR_HI_ZERO 20'h00000
`define SIBC_HTRANS_NONSEQ 2'h2
`define SIBC_HSIZE_WORD 3'h2
`define SIBC_CTL1_RESET 8'h00
`define SIBC_CTL2_RESET 8'h7d
`define SIBC_MODE2_RESET 8'h00
`define SIBC_C1_ENA 7
`define SIBC_C1_RCVINH 6
`define SIBC_C1_MST 5
`define SIBC_C1_DIR 4
`define SIBC_C2_BUSY 7
`define SIBC_C2_SSDIS 6
`define SIBC_C2_DRV 5
`define SIBC_C2_WP 4
`define SIBC_C2_CRST 1
`define SIBC_M2_I2C 0
`define SIBC_HALF_UNIT 10
`define SIBC_CNT_W 16
`endif

/* hdl/sibc_pkg.sv */
// Types shared by the bus control block.
package sibc_pkg;
  typedef enum logic [2:0] {
    SS_IDLE,
    SS_PREP,
    SS_SETUP,
    SS_RISE,
    SS_EDGE,
    SS_HOLD
  } sibc_ss_state_t;
endpackage : sibc_pkg

/* hdl/sibc_sync3.sv */
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module sibc_sync3 #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] q_r;
  logic [WIDTH-1:0] q_nxt;

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      q_r <= INIT;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule : sibc_sync3
`default_nettype wire

/* hdl/sibc_bus_control.sv */
// Control and status logic of the dual-mode serial interface with an AHB-Lite slave.
// Overview of operation
// - Transfer clock select paces master bus timing.
// - Address match with read bit sets transmit.
// - Arbitration loss clears master and transmit bits.
// - Serial overrun in master receive clears master.
// - Disable or reset may disturb busy state.
// - Serial control reset keeps programmed registers.
// - Data drive applies only with protect zero.
// - Serial data drive reads and sets output.
// - Output keeps last bit; manual writes immediate.
// - Serial view reads fixed ones, disable ignored.
// - I2C control reset keeps programmed registers, clears busy and transfer, frees sequencer pins.
// - Clock monitor shows internal clock line level.
// - I2C data drive holds low or releases.
// - Busy write needs disable bit zero.
// - Busy follows start and stop on bus.
// - Busy write one starts, zero stops.
// - Manual start never enables transfers.
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "sibc_params.svh"
module sibc_bus_control #(
  parameter int HALF_UNIT = `SIBC_HALF_UNIT
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  output logic sdo,
  input wire logic tx_bit_valid,
  input wire logic tx_bit,
  input wire logic arb_lost,
  input wire logic overrun,
  input wire logic addr_valid,
  input wire logic [7:0] addr_byte,
  output logic [3:0] clock_select,
  output logic direction_select,
  output logic master_select,
  output logic receive_inhibit,
  output logic bus_interface_enable,
  output logic i2c_mode,
  output logic control_block_reset,
  output logic xfer_enable
);
  logic scl_s;
  logic sda_s;
  logic scl_d_r;
  logic sda_d_r;

  // Bus pins are pulled up, so the synchroniser starts from the idle level.
  sibc_sync3 #(.WIDTH(2), .INIT(2'h3)) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .d({scl_in, sda_in}),
    .q({scl_s, sda_s})
  );

  // Bus slave: address phase captured, write applied in the data phase.
  logic dp_wr_r;
  logic dp_wr_nxt;
  logic [9:0] dp_idx_r;
  logic [9:0] dp_idx_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic ap_valid;
  logic [9:0] ap_idx;
  logic wr_en;
  logic [7:0] wdat;

  // Control registers and their next values.
  logic [7:0] ctl1_r;
  logic [7:0] ctl1_nxt;
  logic [7:0] mode_r;
  logic [7:0] mode_nxt;
  logic sdo_r;
  logic sdo_nxt;
  logic sda_hold_r;
  logic sda_hold_nxt;
  logic crst_r;
  logic crst_nxt;
  logic start_req_r;
  logic start_req_nxt;
  logic stop_req_r;
  logic stop_req_nxt;
  logic i2c;
  logic match;

  // Start and stop sequencer, bus state and pin drivers.
  sibc_pkg::sibc_ss_state_t ss_r;
  sibc_pkg::sibc_ss_state_t ss_nxt;
  logic kind_r;
  logic kind_nxt;
  logic [`SIBC_CNT_W-1:0] cnt_r;
  logic [`SIBC_CNT_W-1:0] cnt_nxt;
  logic [`SIBC_CNT_W-1:0] half_cycles;
  logic scl_low_r;
  logic scl_low_nxt;
  logic sda_fsm_r;
  logic sda_fsm_nxt;
  logic busy_r;
  logic busy_nxt;
  logic xfer_r;
  logic xfer_nxt;
  logic scl_oe_r;
  logic scl_oe_nxt;
  logic sda_oe_r;
  logic sda_oe_nxt;
  logic abort;

  assign ap_valid = hsel && hready && (htrans == `SIBC_HTRANS_NONSEQ) &&
                    (hsize == `SIBC_HSIZE_WORD) &&
                    (haddr[31:12] == `SIBC_ADDR_HI_ZERO);
  assign ap_idx = haddr[11:2];
  assign wr_en = dp_wr_r;
  assign wdat = hwdata[7:0];
  assign i2c = mode_r[`SIBC_M2_I2C];
  assign match = (addr_byte[7:1] == mode_r[7:1]) && addr_byte[0];
  // The divider setting scales the half period of the generated clock.
  assign half_cycles = `SIBC_CNT_W'((32'(ctl1_r[3:0]) + 32'd1) * HALF_UNIT);
  assign abort = crst_r || !ctl1_r[`SIBC_C1_ENA] || !i2c;

  always_comb begin
    ctl1_nxt = ctl1_r;
    mode_nxt = mode_r;
    sdo_nxt = sdo_r;
    sda_hold_nxt = sda_hold_r;
    crst_nxt = 1'b0;
    start_req_nxt = 1'b0;
    stop_req_nxt = 1'b0;
    if (wr_en) begin
      if (dp_idx_r == `SIBC_IDX_CTL1) begin
        ctl1_nxt = wdat;
      end else if (dp_idx_r == `SIBC_IDX_MODE2) begin
        mode_nxt = wdat;
      end else if (dp_idx_r == `SIBC_IDX_CTL2) begin
        crst_nxt = wdat[`SIBC_C2_CRST];
        if (!wdat[`SIBC_C2_WP]) begin
          if (i2c) begin
            sda_hold_nxt = !wdat[`SIBC_C2_DRV];
          end else begin
            sdo_nxt = wdat[`SIBC_C2_DRV];
          end
        end
        // In the serial view the disable bit is inert, so nothing starts.
        if (i2c && !wdat[`SIBC_C2_SSDIS]) begin
          start_req_nxt = wdat[`SIBC_C2_BUSY];
          stop_req_nxt = !wdat[`SIBC_C2_BUSY];
        end
      end
    end
    if (tx_bit_valid && !i2c) begin
      sdo_nxt = tx_bit;
    end
    // Hardware events land after the software write, so they win.
    if (arb_lost && i2c && ctl1_r[`SIBC_C1_MST]) begin
      ctl1_nxt[`SIBC_C1_MST] = 1'b0;
      ctl1_nxt[`SIBC_C1_DIR] = 1'b0;
    end
    if (overrun && !i2c && ctl1_r[`SIBC_C1_MST] && !ctl1_r[`SIBC_C1_DIR]) begin
      ctl1_nxt[`SIBC_C1_MST] = 1'b0;
    end
    if (addr_valid && i2c && match && !ctl1_r[`SIBC_C1_MST] &&
        !ctl1_r[`SIBC_C1_DIR]) begin
      ctl1_nxt[`SIBC_C1_DIR] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl1_r <= `SIBC_CTL1_RESET;
      mode_r <= `SIBC_MODE2_RESET;
      sdo_r <= 1'b1;
      sda_hold_r <= 1'b0;
      crst_r <= 1'b0;
      start_req_r <= 1'b0;
      stop_req_r <= 1'b0;
    end else begin
      ctl1_r <= ctl1_nxt;
      mode_r <= mode_nxt;
      sdo_r <= sdo_nxt;
      sda_hold_r <= sda_hold_nxt;
      crst_r <= crst_nxt;
      start_req_r <= start_req_nxt;
      stop_req_r <= stop_req_nxt;
    end
  end

  // Read data is built from next values so a write followed at once by a
  // read of the same register returns the written contents, except the I2C data drive bit, which reads the old sda_oe_r.
  always_comb begin
    dp_wr_nxt = ap_valid && hwrite;
    dp_idx_nxt = ap_valid ? ap_idx : dp_idx_r;
    hrdata_nxt = hrdata_r;
    if (ap_valid && !hwrite) begin
      hrdata_nxt = 32'h0000_0000;
      if (ap_idx == `SIBC_IDX_CTL1) begin
        hrdata_nxt[7:0] = ctl1_nxt;
      end else if (ap_idx == `SIBC_IDX_MODE2) begin
        hrdata_nxt[7:0] = mode_nxt;
      end else if (ap_idx == `SIBC_IDX_STAT) begin
        hrdata_nxt[1:0] = {ss_r != sibc_pkg::SS_IDLE, xfer_r};
      end else if (ap_idx == `SIBC_IDX_CTL2) begin
        if (mode_nxt[`SIBC_M2_I2C]) begin
          hrdata_nxt[7:0] = {busy_r, 1'b1, !sda_oe_r, 1'b1, scl_s,
                             1'b1, 1'b0, 1'b1};
        end else begin
          hrdata_nxt[7:0] = {1'b0, 1'b1, sdo_nxt, 1'b1, 1'b1,
                             1'b1, 1'b0, 1'b1};
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r <= 1'b0;
      dp_idx_r <= 10'h000;
      hrdata_r <= 32'h0000_0000;
    end else begin
      dp_wr_r <= dp_wr_nxt;
      dp_idx_r <= dp_idx_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  always_comb begin
    ss_nxt = ss_r;
    kind_nxt = kind_r;
    cnt_nxt = (cnt_r != '0) ? cnt_r - `SIBC_CNT_W'(1) : cnt_r;
    scl_low_nxt = scl_low_r;
    sda_fsm_nxt = sda_fsm_r;
    xfer_nxt = xfer_r;
    busy_nxt = busy_r;
    if (scl_s && scl_d_r && sda_d_r && !sda_s) begin
      busy_nxt = 1'b1;
    end else if (scl_s && scl_d_r && !sda_d_r && sda_s) begin
      busy_nxt = 1'b0;
    end
    unique case (ss_r)
      sibc_pkg::SS_IDLE: begin
        if (start_req_r || stop_req_r) begin
          kind_nxt = start_req_r;
          cnt_nxt = half_cycles;
          ss_nxt = sibc_pkg::SS_PREP;
          // Pulling the clock low first keeps a stop from reading as a start.
          if (stop_req_r) begin
            scl_low_nxt = 1'b1;
          end
        end
      end
      sibc_pkg::SS_PREP: begin
        if (cnt_r == '0) begin
          sda_fsm_nxt = !kind_r;
          cnt_nxt = half_cycles;
          ss_nxt = sibc_pkg::SS_SETUP;
        end
      end
      sibc_pkg::SS_SETUP: begin
        if (cnt_r == '0) begin
          scl_low_nxt = 1'b0;
          ss_nxt = sibc_pkg::SS_RISE;
        end
      end
      sibc_pkg::SS_RISE: begin
        // A peer may stretch the clock; wait until the line is really high.
        if (scl_s) begin
          cnt_nxt = half_cycles;
          ss_nxt = sibc_pkg::SS_EDGE;
        end
      end
      sibc_pkg::SS_EDGE: begin
        if (cnt_r == '0) begin
          sda_fsm_nxt = kind_r;
          cnt_nxt = half_cycles;
          ss_nxt = sibc_pkg::SS_HOLD;
        end
      end
      sibc_pkg::SS_HOLD: begin
        if (cnt_r == '0) begin
          scl_low_nxt = kind_r;
          xfer_nxt = kind_r;
          ss_nxt = sibc_pkg::SS_IDLE;
        end
      end
    endcase
    // Disable and control reset drop the busy state to a known zero.
    if (abort) begin
      ss_nxt = sibc_pkg::SS_IDLE;
      scl_low_nxt = 1'b0;
      sda_fsm_nxt = 1'b0;
      xfer_nxt = 1'b0;
      busy_nxt = 1'b0;
      cnt_nxt = '0;
    end
    scl_oe_nxt = i2c && ctl1_nxt[`SIBC_C1_ENA] && scl_low_nxt;
    sda_oe_nxt = i2c && ctl1_nxt[`SIBC_C1_ENA] &&
                 (sda_hold_nxt || sda_fsm_nxt);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ss_r <= sibc_pkg::SS_IDLE;
      kind_r <= 1'b0;
      cnt_r <= '0;
      scl_low_r <= 1'b0;
      sda_fsm_r <= 1'b0;
      xfer_r <= 1'b0;
      busy_r <= 1'b0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      ss_r <= ss_nxt;
      kind_r <= kind_nxt;
      cnt_r <= cnt_nxt;
      scl_low_r <= scl_low_nxt;
      sda_fsm_r <= sda_fsm_nxt;
      xfer_r <= xfer_nxt;
      busy_r <= busy_nxt;
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      scl_oe_r <= scl_oe_nxt;
      sda_oe_r <= sda_oe_nxt;
    end
  end

  // Open-drain pins only ever drive low; the level sits in the enable.
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_oe_r;
  assign sda_oe = sda_oe_r;
  assign sdo = sdo_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign clock_select = ctl1_r[3:0];
  assign direction_select = ctl1_r[`SIBC_C1_DIR];
  assign master_select = ctl1_r[`SIBC_C1_MST];
  assign receive_inhibit = ctl1_r[`SIBC_C1_RCVINH];
  assign bus_interface_enable = ctl1_r[`SIBC_C1_ENA];
  assign i2c_mode = i2c;
  assign control_block_reset = crst_r;
  assign xfer_enable = xfer_r;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_arb;
    (arb_lost && i2c && master_select) |=> !master_select && !direction_select;
  endproperty
  a_arb: assert property (p_arb) else $error("arbitration loss kept master");

  property p_ovr;
    (overrun && !i2c && master_select && !direction_select) |=> !master_select;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun kept master");

  property p_match;
    (addr_valid && i2c && match && !master_select && !direction_select)
      |=> direction_select;
  endproperty
  a_match: assert property (p_match) else $error("address match ignored");

  property p_wp;
    (wr_en && dp_idx_r == `SIBC_IDX_CTL2 && wdat[`SIBC_C2_WP] && !tx_bit_valid)
      |=> $stable(sdo_r) && $stable(sda_hold_r);
  endproperty
  a_wp: assert property (p_wp) else $error("protected data drive changed");

  property p_drv_low;
    (wr_en && dp_idx_r == `SIBC_IDX_CTL2 && !wdat[`SIBC_C2_WP] &&
     !wdat[`SIBC_C2_DRV] && i2c && bus_interface_enable && !arb_lost)
      |=> sda_oe;
  endproperty
  a_drv_low: assert property (p_drv_low) else $error("data line not held low");

  property p_ssdis;
    (wr_en && dp_idx_r == `SIBC_IDX_CTL2 && wdat[`SIBC_C2_SSDIS])
      |=> !start_req_r && !stop_req_r;
  endproperty
  a_ssdis: assert property (p_ssdis) else $error("disabled busy write acted");

  property p_busy_set;
    (scl_s && scl_d_r && sda_d_r && !sda_s && !abort) |=> busy_r;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not set on start");

  property p_busy_clr;
    (scl_s && scl_d_r && !sda_d_r && sda_s) |=> !busy_r;
  endproperty
  a_busy_clr: assert property (p_busy_clr) else $error("busy not cleared on stop");

  property p_edge_high;
    ($past(ss_r) == sibc_pkg::SS_EDGE && $changed(sda_fsm_r)) |-> !scl_low_r;
  endproperty
  a_edge_high: assert property (p_edge_high) else $error("data edge with clock low");

  property p_xfer;
    $rose(xfer_r) |-> $past(ss_r) == sibc_pkg::SS_HOLD && kind_r;
  endproperty
  a_xfer: assert property (p_xfer) else $error("transfer enabled without start");

  property p_sdo;
    (!i2c && tx_bit_valid) |=> sdo == $past(tx_bit);
  endproperty
  a_sdo: assert property (p_sdo) else $error("last bit not kept");

  property p_start_done;
    (ss_r == sibc_pkg::SS_HOLD && kind_r) ##1 xfer_r;
  endproperty
  c_start_done: cover property (p_start_done);

  property p_stop_done;
    (ss_r == sibc_pkg::SS_HOLD && !kind_r) ##1 (ss_r == sibc_pkg::SS_IDLE);
  endproperty
  c_stop_done: cover property (p_stop_done);

  property p_arb_seen;
    arb_lost && i2c && master_select;
  endproperty
  c_arb_seen: cover property (p_arb_seen);

  property p_match_seen;
    addr_valid && i2c && match;
  endproperty
  c_match_seen: cover property (p_match_seen);
endmodule : sibc_bus_control
`default_nettype wire

/* bench/sibc_bus_model.sv */
// Bus-side partner: pull-ups, clock stretching and condition counters.
`timescale 1ns/1ps
`default_nettype none
module sibc_bus_model (
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic slow,
  input wire logic hold_scl,
  output logic scl,
  output logic sda,
  output var int n_start,
  output var int n_stop
);
  logic stretch = 1'b0;
  // A slow peer keeps the clock low for 128 ns, sixteen hclk periods, after release.
  always @(negedge scl_oe) begin
    if (slow) begin
      stretch = 1'b1;
      #128 stretch = 1'b0;
    end
  end
  // Released lines float to the pull-up level.
  assign scl = !(scl_oe | hold_scl | stretch);
  assign sda = !sda_oe;
  initial begin
    n_start = 0;
    n_stop = 0;
  end
  always @(negedge sda) if (scl) n_start++;
  always @(posedge sda) if (scl) n_stop++;
endmodule : sibc_bus_model
`default_nettype wire

/* bench/tb_serial_iface_bus_control.sv */
// Self-checking bench for the serial interface bus control block.
`timescale 1ns/1ps
`default_nettype none
`include "sibc_params.svh"
module tb_serial_iface_bus_control;
  localparam logic [9:0] C1 = `SIBC_IDX_CTL1;
  localparam logic [9:0] C2 = `SIBC_IDX_CTL2;
  localparam logic [9:0] M2 = `SIBC_IDX_MODE2;
  localparam logic [9:0] ST = `SIBC_IDX_STAT;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, scl, sda;
  logic scl_oe, sda_oe, sdo, tx_bit_valid, tx_bit, arb_lost, overrun;
  logic addr_valid, slow, hold_scl, direction_select, master_select;
  logic receive_inhibit, bus_interface_enable, i2c_mode;
  logic control_block_reset, xfer_enable;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] addr_byte;
  logic [3:0] clock_select;
  int n_fail, check_count, n_start, n_stop, n_crst;

  sibc_bus_control #(.HALF_UNIT(2)) DUT (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .scl_in(scl), .sda_in(sda), .scl_out(), .scl_oe, .sda_out(), .sda_oe,
    .sdo, .tx_bit_valid, .tx_bit, .arb_lost, .overrun, .addr_valid,
    .addr_byte, .clock_select, .direction_select, .master_select,
    .receive_inhibit, .bus_interface_enable, .i2c_mode,
    .control_block_reset, .xfer_enable
  );
  sibc_bus_model peer (
    .scl_oe, .sda_oe, .slow, .hold_scl, .scl, .sda, .n_start, .n_stop
  );

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) if (control_block_reset === 1'b1) n_crst++;

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc

  // The master waits for hready in both phases, never assuming a latency.
  task automatic xfer(input logic w, input logic [9:0] idx,
                      input logic [7:0] wd);
    @(posedge hclk);
    haddr <= {`SIBC_ADDR_HI_ZERO, idx, 2'h0};
    hwrite <= w;
    hsize <= `SIBC_HSIZE_WORD;
    hsel <= 1'b1;
    htrans <= `SIBC_HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h000000, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask : wr

  task automatic rdc(input string nm, input logic [9:0] idx,
                     input logic [31:0] exp);
    xfer(1'b0, idx, 8'h00);
    check(nm, rd, exp);
  endtask : rdc

  // One-cycle pulse: 0 arbitration, 1 overrun, 2 address, 3 shifted bit.
  task automatic ev(input int k);
    @(posedge hclk);
    {tx_bit_valid, addr_valid, overrun, arb_lost} <= 4'h1 << k;
    @(posedge hclk);
    {tx_bit_valid, addr_valid, overrun, arb_lost} <= 4'h0;
    cyc(3);
  endtask : ev

  task automatic idle;
    cyc(3);
    for (int i = 0; i < 200; i++) begin
      xfer(1'b0, ST, 8'h00);
      if (rd[1] === 1'b0) break;
    end
    check("sequencer idle", rd[1], 1'b0);
  endtask : idle

  task automatic t_reset;
    check("hresp", hresp, 1'b0);
    check("hreadyout", hreadyout, 1'b1);
    check("sdo", sdo, 1'b1);
    rdc("ctl1", C1, 32'h00);
    rdc("ctl2", C2, 32'h7d);
    rdc("mode2", M2, 32'h00);
    rdc("unmapped", 10'h16a, 32'h00);
  endtask : t_reset

  task automatic t_manual;
    int s0 = n_start;
    int p0 = n_stop;
    wr(M2, 8'h01);
    wr(C1, 8'h80);
    wr(C2, 8'hdd);
    cyc(6);
    check("protected", sda_oe, 1'b0);
    check("enable", bus_interface_enable, 1'b1);
    check("i2c mode", i2c_mode, 1'b1);
    wr(C2, 8'hcd);
    cyc(6);
    rdc("held low", C2, 32'hdd);
    check("sda_oe", sda_oe, 1'b1);
    check("manual start", xfer_enable, 1'b0);
    wr(C2, 8'hed);
    cyc(6);
    rdc("released", C2, 32'h7d);
    check("wire starts", n_start - s0, 1);
    check("wire stops", n_stop - p0, 1);
  endtask : t_manual

  task automatic t_sclmon;
    hold_scl <= 1'b1;
    cyc(6);
    rdc("scl low", C2, 32'h75);
    hold_scl <= 1'b0;
    cyc(6);
    rdc("scl high", C2, 32'h7d);
  endtask : t_sclmon

  task automatic t_startstop(input logic sl);
    int s0 = n_start;
    int p0 = n_stop;
    slow <= sl;
    wr(C2, 8'hfd);
    cyc(20);
    rdc("disabled", ST, 32'h0);
    wr(C2, 8'hbd);
    idle;
    rdc("started", ST, 32'h1);
    rdc("busy", C2, 32'hd5);
    check("xfer port", xfer_enable, 1'b1);
    check("scl low", scl_oe, 1'b1);
    wr(C2, 8'h3d);
    idle;
    rdc("stopped", ST, 32'h0);
    rdc("free", C2, 32'h7d);
    check("starts", n_start - s0, 1);
    check("stops", n_stop - p0, 1);
  endtask : t_startstop

  task automatic t_abort;
    int c0 = n_crst;
    wr(C1, 8'hf3);
    cyc(3);
    check("cks", clock_select, 4'h3);
    check("rcv inhibit", receive_inhibit, 1'b1);
    check("direction", direction_select, 1'b1);
    wr(C2, 8'hbd);
    cyc(4);
    // Reset lands mid-sequence so the abort path is exercised.
    wr(C2, 8'hdf);
    idle;
    check("reset pulse", n_crst - c0, 1);
    rdc("ctl1 kept", C1, 32'hf3);
    rdc("mode2 kept", M2, 32'h01);
    rdc("aborted", ST, 32'h0);
    check("sda free", sda_oe, 1'b0);
    check("scl free", scl_oe, 1'b0);
  endtask : t_abort

  task automatic t_events;
    logic [7:0] ab [3] = '{8'h54, 8'h57, 8'h55};
    logic [31:0] ex [3] = '{32'h80, 32'h80, 32'h90};
    wr(C1, 8'hb0);
    ev(0);
    rdc("arb lost", C1, 32'h80);
    check("master", master_select, 1'b0);
    wr(M2, 8'h55);
    for (int i = 0; i < 3; i++) begin
      addr_byte <= ab[i];
      ev(2);
      rdc("addr match", C1, ex[i]);
    end
  endtask : t_events

  task automatic t_serial;
    wr(M2, 8'h00);
    wr(C1, 8'h20);
    ev(1);
    rdc("overrun", C1, 32'h00);
    wr(C2, 8'hcd);
    cyc(3);
    check("sdo low", sdo, 1'b0);
    check("serial mode", i2c_mode, 1'b0);
    rdc("serial view", C2, 32'h5d);
    tx_bit <= 1'b1;
    ev(3);
    check("last bit", sdo, 1'b1);
    rdc("sdo high", C2, 32'h7d);
    wr(C2, 8'h8d);
    cyc(20);
    check("no drive", sda_oe, 1'b0);
    rdc("no start", ST, 32'h0);
    wr(C1, 8'h25);
    wr(C2, 8'h1f);
    // Interrupt enables sit outside this block, so no transfer follows.
    cyc(3);
    rdc("kept", C1, 32'h25);
    check("sdo kept", sdo, 1'b0);
  endtask : t_serial

  initial begin
    #200000;
    n_fail++;
    tally_and_finish;
  end

  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, tx_bit_valid, tx_bit, arb_lost, overrun} = '0;
    {addr_valid, slow, hold_scl} = '0;
    haddr = '0;
    hwdata = '0;
    htrans = '0;
    hsize = '0;
    addr_byte = '0;
    n_fail = 0;
    check_count = 0;
    n_crst = 0;
    cyc(10);
    hresetn <= 1'b1;
    t_reset;
    t_manual;
    t_sclmon;
    t_startstop(1'b0);
    t_startstop(1'b1);
    t_abort;
    t_events;
    t_serial;
    tally_and_finish;
  end
endmodule : tb_serial_iface_bus_control
`default_nettype wire
